// [rtl/fm_map.svh]
// Constants of the flash command sequencer
`ifndef FM_MAP_SVH
`define FM_MAP_SVH
`define FM_NUM_BANKS     4
`define FM_RANGE_LSB     18
`define FM_BANK_MSB      18
`define FM_BANK_LSB      17
`define FM_PAGE_MSB      9
`define SZ_BYTE          2'h0
`define SZ_HALF          2'h1
`define SZ_WORD          2'h2
`define SZ_BAD           2'h3
`define CMD_VERIFY       7'h05
`define CMD_PROGRAM      7'h20
`define CMD_PAGE_ERASE   7'h40
`define CMD_MASS_ERASE   7'h41
`define ST_BUF_EMPTY     7
`define ST_PROT          5
`define ST_ACC           4
`define ST_BLANK         2
`define DIV_PRESCALE_BIT 6
`define PRESCALE_MAX     3'h7
`define CLK_PERIOD_NS    10
`define SA_TIMEOUT_NS    50
`define SA_TIMEOUT_CYC   (`SA_TIMEOUT_NS / `CLK_PERIOD_NS)
`define T_VERIFY         8'h04
`define T_PROGRAM        8'h08
`define T_PAGE_ERASE     8'h20
`define T_MASS_ERASE     8'hC0
`endif

// [rtl/fm_pkg.sv]
// Types shared by the flash command sequencer
package fm_pkg;
  typedef logic [6:0] cmd_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_WORD, SEQ_CMD} seq_e;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bus_req_s;
  typedef struct packed {
    logic        ack;
    logic        terr;
    logic [31:0] rdata;
  } bus_rsp_s;
  typedef struct packed {
    logic buffer_empty;
    logic command_complete;
    logic protection_violation;
    logic access_error;
    logic blank;
    logic divider_loaded;
  } status_s;
  typedef struct packed {
    logic        start;
    logic [1:0]  bank;
    cmd_t        cmd;
    logic [31:0] addr;
    logic [31:0] data;
  } op_s;
endpackage

// [rtl/fm_clock_divider.sv]
// State-machine clock tick generator
`timescale 1ns/1ps
`default_nettype none
`include "fm_map.svh"
module fm_clock_divider
  import fm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       load,
  input  wire logic [6:0] wdata,
  output logic            divider_loaded,
  output logic            tick
);
  logic       prescale_by_eight_q;
  logic [5:0] div_q;
  logic [2:0] pre_cnt_q;
  logic [5:0] div_cnt_q;
  logic       pre_tick;

  assign pre_tick = !prescale_by_eight_q || pre_cnt_q == '0;
  assign tick = divider_loaded && pre_tick && div_cnt_q == '0;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      divider_loaded      <= 1'b0;
      prescale_by_eight_q <= 1'b0;
      div_q               <= '0;
    end else if (load) begin
      divider_loaded      <= 1'b1;
      prescale_by_eight_q <= wdata[`DIV_PRESCALE_BIT];
      div_q               <= wdata[5:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pre_cnt_q <= '0;
      div_cnt_q <= '0;
    end else if (load) begin
      pre_cnt_q <= `PRESCALE_MAX;
      div_cnt_q <= wdata[5:0];
    end else if (pre_tick) begin
      pre_cnt_q <= `PRESCALE_MAX;
      div_cnt_q <= (div_cnt_q == '0) ? div_q : div_cnt_q - 6'h01;
    end else begin
      pre_cnt_q <= pre_cnt_q - 3'h1;
    end
  end

  AST_DIVIDER_LOADED_SET: assert property (@(posedge clk) disable iff (reset)
    load |=> divider_loaded ##1 divider_loaded)
    else $error("divider loaded flag not set by write");
  AST_DIV_BY_TWO: assert property (@(posedge clk) disable iff (reset)
    tick && !prescale_by_eight_q && div_q == 6'h01 && !load ##1 !load
      |-> !tick ##1 (tick || load))
    else $error("state-machine tick spacing wrong");
endmodule // fm_clock_divider
`default_nettype wire

// [rtl/fm_bank_engine.sv]
// Per block pair command execution timer
`timescale 1ns/1ps
`default_nettype none
`include "fm_map.svh"
module fm_bank_engine
  import fm_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic tick,
  input  wire logic start,
  input  wire cmd_t cmd,
  output logic      busy,
  output logic      done,
  output cmd_t      cmd_q
);
  logic [7:0] cnt_q;
  logic [7:0] dur;

  always_comb begin
    case (cmd)
      `CMD_VERIFY:     dur = `T_VERIFY;
      `CMD_PROGRAM:    dur = `T_PROGRAM;
      `CMD_PAGE_ERASE: dur = `T_PAGE_ERASE;
      default:         dur = `T_MASS_ERASE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy  <= 1'b0;
      done  <= 1'b0;
      cnt_q <= '0;
      cmd_q <= '0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy  <= 1'b1;
        cnt_q <= dur;
        cmd_q <= cmd;
      end else if (busy && tick) begin
        if (cnt_q == '0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 8'h01;
        end
      end
    end
  end

  AST_ENG_TICK_ONLY: assert property (@(posedge clk) disable iff (reset)
    busy && !tick |=> busy && $stable(cnt_q))
    else $error("engine advanced without a tick");
endmodule // fm_bank_engine
`default_nettype wire

// [rtl/fm_sequencer.sv]
// Flash array access and command sequencer top
`timescale 1ns/1ps
`default_nettype none
`include "fm_map.svh"
module fm_sequencer
  import fm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire bus_req_s    bus_req,
  output bus_rsp_s         bus_rsp,
  input  wire logic        key_access_enable,
  input  wire logic [1:0]  bank_select,
  input  wire logic        clkdiv_wr,
  input  wire logic [6:0]  clkdiv_wdata,
  input  wire logic        cmd_wr,
  input  wire logic [7:0]  cmd_wdata,
  input  wire logic        status_wr,
  input  wire logic [7:0]  status_wdata,
  input  wire logic [3:0]  protected_any,
  input  wire logic        addr_protected,
  input  wire logic [3:0]  verify_pass,
  input  wire logic [31:0] flash_rdata,
  output logic [31:0]      flash_addr,
  output logic             sense_amp_en,
  output status_s          status,
  output op_s              op
);
  localparam int NB = `FM_NUM_BANKS;

  logic        in_range, misalign, rd_ok, wr_valid, wr_bad;
  logic        div_loaded, fm_tick, err_any, cmd_ok;
  logic        take_word, take_cmd, launch, set_acc, set_protection_violation_flag;
  logic [2:0]  sa_cnt_q;
  cmd_t        cmd_in;
  seq_e        seq_q     [NB];
  logic [31:0] buf_addr_q[NB];
  logic [31:0] buf_data_q[NB];
  cmd_t        buf_cmd_q [NB];
  cmd_t        eng_cmd   [NB];
  logic [NB-1:0] pend_q, busy, done, eng_start, acc_q, protection_violation_flag_q, blank_q;

  assign cmd_in = cmd_wdata[6:0];
  assign err_any = |(acc_q | protection_violation_flag_q);
  assign flash_addr = bus_req.addr;

  always_comb begin
    in_range = bus_req.valid && bus_req.addr[31:`FM_RANGE_LSB] == '0;
    misalign = (bus_req.size == `SZ_HALF && bus_req.addr[0])
            || (bus_req.size == `SZ_WORD && bus_req.addr[1:0] != '0)
            || bus_req.size == `SZ_BAD;
    rd_ok    = in_range && !bus_req.write && !misalign;
    wr_valid = in_range && bus_req.write;
    wr_bad   = wr_valid && (bus_req.size != `SZ_WORD || misalign);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bus_rsp <= '0;
    end else begin
      bus_rsp.ack   <= in_range && !misalign && !wr_bad;
      bus_rsp.terr  <= in_range && (misalign || wr_bad);
      bus_rsp.rdata <= rd_ok ? flash_rdata : '0;
    end
  end

  // sense amp timeout saves power at slow clocks
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sa_cnt_q <= '0;
    end else if (rd_ok) begin
      sa_cnt_q <= 3'(`SA_TIMEOUT_CYC - 1);
    end else if (sa_cnt_q != '0) begin
      sa_cnt_q <= sa_cnt_q - 3'h1;
    end
  end
  assign sense_amp_en = rd_ok || sa_cnt_q != '0;

  fm_clock_divider u_div (
    .clk            (clk),
    .reset          (reset),
    .load           (clkdiv_wr),
    .wdata          (clkdiv_wdata),
    .divider_loaded (div_loaded),
    .tick           (fm_tick)
  );

  assign cmd_ok = cmd_in == `CMD_VERIFY || cmd_in == `CMD_PROGRAM
               || cmd_in == `CMD_PAGE_ERASE || cmd_in == `CMD_MASS_ERASE;

  // Sequence monitor for the selected bank; one strobe per cycle
  always_comb begin
    take_word = 1'b0;
    take_cmd  = 1'b0;
    launch    = 1'b0;
    set_acc   = 1'b0;
    set_protection_violation_flag = 1'b0;
    // key access writes bypass the sequencer
    if (wr_valid && !key_access_enable) begin
      // no word taken before divider load
      if (wr_bad || !div_loaded || pend_q[bank_select]
          || seq_q[bank_select] != SEQ_IDLE
          || bus_req.addr[`FM_BANK_MSB:`FM_BANK_LSB] != bank_select)
        set_acc = 1'b1;
      else if (addr_protected)
        set_protection_violation_flag = 1'b1;
      else
        take_word = 1'b1;
    end else if (cmd_wr && !pend_q[bank_select]) begin
      if (seq_q[bank_select] != SEQ_WORD || !cmd_ok)
        set_acc = 1'b1;
      else if (cmd_in == `CMD_MASS_ERASE && protected_any[bank_select])
        set_protection_violation_flag = 1'b1;
      else
        take_cmd = 1'b1;
    end else if (clkdiv_wr && seq_q[bank_select] != SEQ_IDLE) begin
      set_acc = 1'b1;
    end else if (status_wr && seq_q[bank_select] != SEQ_IDLE) begin
      if (!status_wdata[`ST_BUF_EMPTY] || seq_q[bank_select] == SEQ_WORD)
        set_acc = 1'b1;
      else if (!err_any)
        launch = 1'b1;
    end
  end

  // One engine starts per cycle so the op port stays single
  always_comb begin
    eng_start = '0;
    for (int i = 0; i < NB; i++) begin
      if (pend_q[i] && !busy[i] && eng_start == '0)
        eng_start[i] = 1'b1;
    end
  end

  for (genvar b = 0; b < NB; b++) begin : g_bank
    logic sel;
    assign sel = bank_select == 2'(b);

    always_ff @(posedge clk or posedge reset) begin
      if (reset)
        seq_q[b] <= SEQ_IDLE;
      else if (sel && (set_acc || set_protection_violation_flag || launch))
        seq_q[b] <= SEQ_IDLE;
      else if (sel && take_word)
        seq_q[b] <= SEQ_WORD;
      else if (sel && take_cmd)
        seq_q[b] <= SEQ_CMD;
    end

    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        buf_addr_q[b] <= '0;
        buf_data_q[b] <= '0;
        buf_cmd_q[b]  <= '0;
      end else begin
        if (sel && take_word) begin
          buf_addr_q[b] <= bus_req.addr;
          buf_data_q[b] <= bus_req.wdata;
        end
        if (sel && take_cmd)
          buf_cmd_q[b] <= cmd_in;
      end
    end

    always_ff @(posedge clk or posedge reset) begin
      if (reset)
        pend_q[b] <= 1'b0;
      else if (sel && launch)
        pend_q[b] <= 1'b1;
      else if (eng_start[b])
        pend_q[b] <= 1'b0;
    end

    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        acc_q[b]   <= 1'b0;
        protection_violation_flag_q[b] <= 1'b0;
      end else begin
        if (sel && set_acc)
          acc_q[b] <= 1'b1;
        else if (sel && status_wr && status_wdata[`ST_ACC])
          acc_q[b] <= 1'b0;
        if (sel && set_protection_violation_flag)
          protection_violation_flag_q[b] <= 1'b1;
        else if (sel && status_wr && status_wdata[`ST_PROT])
          protection_violation_flag_q[b] <= 1'b0;
      end
    end

    always_ff @(posedge clk or posedge reset) begin
      if (reset)
        blank_q[b] <= 1'b0;
      else if (done[b] && eng_cmd[b] == `CMD_VERIFY && verify_pass[b])
        blank_q[b] <= 1'b1;
      else if (sel && status_wr && status_wdata[`ST_BLANK])
        blank_q[b] <= 1'b0;
    end

    fm_bank_engine u_eng (
      .clk   (clk),
      .reset (reset),
      .tick  (fm_tick),
      .start (eng_start[b]),
      .cmd   (buf_cmd_q[b]),
      .busy  (busy[b]),
      .done  (done[b]),
      .cmd_q (eng_cmd[b])
    );
  end

  always_comb begin
    status.buffer_empty         = !pend_q[bank_select];
    // Held low through done so blank is settled when complete reads 1
    status.command_complete     = !pend_q[bank_select] && !busy[bank_select]
                                  && !done[bank_select];
    status.protection_violation = protection_violation_flag_q[bank_select];
    status.access_error         = acc_q[bank_select];
    status.blank                = blank_q[bank_select];
    status.divider_loaded       = div_loaded;
  end

  // Operation handed to the array; data only matters for program
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      op <= '0;
    end else begin
      op.start <= 1'b0;
      for (int i = 0; i < NB; i++) begin
        if (eng_start[i]) begin
          op.start <= 1'b1;
          op.bank  <= 2'(i);
          op.cmd   <= buf_cmd_q[i];
          op.addr  <= buf_addr_q[i];
          op.data  <= '0;
          if (buf_cmd_q[i] == `CMD_PAGE_ERASE)
            op.addr[`FM_PAGE_MSB:0] <= '0;
          if (buf_cmd_q[i] == `CMD_PROGRAM)
            op.data <= buf_data_q[i];
        end
      end
    end
  end

  sequence s_read;
    rd_ok;
  endsequence
  sequence s_quiet5;
    (!rd_ok) [*5];
  endsequence

  AST_READ_ONE_CYCLE: assert property (@(posedge clk) disable iff (reset)
    s_read |=> bus_rsp.ack && !bus_rsp.terr)
    else $error("aligned read not answered next cycle");
  AST_MISALIGN_TERR: assert property (@(posedge clk) disable iff (reset)
    in_range && misalign |=> bus_rsp.terr && !bus_rsp.ack)
    else $error("misaligned access not errored");
  AST_SUBWORD_WRITE: assert property (@(posedge clk) disable iff (reset)
    wr_valid && bus_req.size != `SZ_WORD |=> bus_rsp.terr)
    else $error("subword array write not errored");
  AST_SA_TIMEOUT: assert property (@(posedge clk) disable iff (reset)
    s_read ##1 s_quiet5 |-> !sense_amp_en)
    else $error("sense amp enable stayed on");
  AST_SA_HOLD: assert property (@(posedge clk) disable iff (reset)
    s_read |=> sense_amp_en [*4])
    else $error("sense amp enable dropped early");
  AST_LAUNCH_FULL: assert property (@(posedge clk) disable iff (reset)
    launch |=> !status.buffer_empty || $changed(bank_select)
      || eng_start[$past(bank_select)])
    else $error("launch did not fill buffer");
  AST_ERR_BLOCKS: assert property (@(posedge clk) disable iff (reset)
    err_any && status_wr |=> !$rose(pend_q[$past(bank_select)]))
    else $error("launch with error flag set");
  AST_ABORT_ACC: assert property (@(posedge clk) disable iff (reset)
    status_wr && !status_wdata[`ST_BUF_EMPTY] && !wr_valid && !cmd_wr
      && !clkdiv_wr && seq_q[bank_select] != SEQ_IDLE
      |=> acc_q[$past(bank_select)] && seq_q[$past(bank_select)] == SEQ_IDLE)
    else $error("zero write did not abort");
  AST_BAD_CMD: assert property (@(posedge clk) disable iff (reset)
    cmd_wr && !wr_valid && !pend_q[bank_select] && !cmd_ok
      |=> acc_q[$past(bank_select)])
    else $error("invalid command not flagged");
  AST_CMD_IGNORED: assert property (@(posedge clk) disable iff (reset)
    cmd_wr && !wr_valid && pend_q[bank_select]
      |=> $stable(buf_cmd_q[$past(bank_select)]))
    else $error("command taken while buffer full");
endmodule // fm_sequencer
`default_nettype wire

// [test/fm_flash_model.sv]
// Flash array read data model
`timescale 1ns/1ps
`default_nettype none
module fm_flash_model (
  input  wire logic [31:0] addr,
  output logic [31:0]      rdata
);
  // Data tied to the address so stale or shifted words show up
  assign rdata = {addr[15:0] ^ 16'hA5C3, ~addr[15:0]};
endmodule // fm_flash_model
`default_nettype wire

// [test/test_fm_sequencer.sv]
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
`include "fm_map.svh"
module test_fm_sequencer
  import fm_pkg::*;
;
  localparam int W_DIV  = 0;
  localparam int W_CMD  = 1;
  localparam int W_STAT = 2;
  logic        clk;
  logic        reset;
  bus_req_s    bus_req;
  bus_rsp_s    bus_rsp;
  logic        key_access_enable;
  logic [1:0]  bank_select;
  logic        clkdiv_wr;
  logic [6:0]  clkdiv_wdata;
  logic        cmd_wr;
  logic [7:0]  cmd_wdata;
  logic        status_wr;
  logic [7:0]  status_wdata;
  logic [3:0]  protected_any;
  logic        addr_protected;
  logic [3:0]  verify_pass;
  logic [31:0] flash_rdata;
  logic [31:0] flash_addr;
  logic        sense_amp_en;
  status_s     status;
  op_s         op;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          n;

  fm_sequencer i_fm_sequencer (
    .clk, .reset, .bus_req, .bus_rsp, .key_access_enable, .bank_select,
    .clkdiv_wr, .clkdiv_wdata, .cmd_wr, .cmd_wdata, .status_wr,
    .status_wdata, .protected_any, .addr_protected, .verify_pass,
    .flash_rdata, .flash_addr, .sense_amp_en, .status, .op
  );

  fm_flash_model i_fm_flash_model (
    .addr  (flash_addr),
    .rdata (flash_rdata)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Longest path is a mass erase plus a few slow programs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      close_out();
    end
  end

  function automatic logic [31:0] exp_rd(input logic [31:0] a);
    return {a[15:0] ^ 16'hA5C3, ~a[15:0]};
  endfunction

  task automatic chk_val(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_stat(input string name, input logic [5:0] exp);
    num_checks++;
    if (status !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, status);
    end
  endtask

  task automatic close_out();
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One-cycle request; answer is {ack, terr} seen after the taking edge
  task automatic bus(input logic w, input logic [1:0] sz,
                     input logic [31:0] a, input logic [31:0] d,
                     input logic [1:0] exp);
    @(posedge clk);
    bus_req <= '{1'b1, w, sz, a, d};
    @(posedge clk);
    bus_req.valid <= 1'b0;
    #1;
    chk_val("bus_answer", exp, {bus_rsp.ack, bus_rsp.terr});
    chk_val("bus_rdata", (exp == 2'h2 && !w) ? exp_rd(a) : 32'h0,
            bus_rsp.rdata);
  endtask

  task automatic strobe(input int which, input logic [7:0] v);
    @(posedge clk);
    clkdiv_wr    <= (which == W_DIV);
    cmd_wr       <= (which == W_CMD);
    status_wr    <= (which == W_STAT);
    clkdiv_wdata <= v[6:0];
    cmd_wdata    <= v;
    status_wdata <= v;
    @(posedge clk);
    clkdiv_wr <= 1'b0;
    cmd_wr    <= 1'b0;
    status_wr <= 1'b0;
    #1;
  endtask

  task automatic seq(input logic [31:0] a, input logic [31:0] d,
                     input logic [7:0] c);
    #1;
    chk_val("buf_empty", 32'h1, status.buffer_empty);
    bus(1'b1, `SZ_WORD, a, d, 2'h2);
    strobe(W_CMD, c);
    strobe(W_STAT, 8'h80);
  endtask

  task automatic wait_start(input cmd_t c, input logic [31:0] a,
                            input logic [31:0] d);
    n = 0;
    while (op.start !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_val("op_start", 32'h1, op.start);
    chk_val("op_cmd", c, op.cmd);
    chk_val("op_addr", a, op.addr);
    chk_val("op_data", d, op.data);
    chk_val("op_bank", bank_select, op.bank);
  endtask

  // Leaves the cycle count of the wait in n
  task automatic wait_done();
    n = 0;
    while (status.command_complete !== 1'b1 && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_val("complete", 32'h1, status.command_complete);
  endtask

  // Tick period is prescale times divider plus one; done after 9 ticks
  task automatic timed_prog(input logic [6:0] dv, input int lo,
                            input int hi);
    strobe(W_DIV, {1'b0, dv});
    seq(32'h0000_0040, 32'h0000_0001, 8'h20);
    wait_start(`CMD_PROGRAM, 32'h0000_0040, 32'h0000_0001);
    wait_done();
    chk_val("prog_cycles", 32'h1, (n >= lo && n <= hi));
  endtask

  initial begin
    reset = 1'b1;
    bus_req = '0;
    key_access_enable = 1'b0;
    bank_select = 2'h0;
    clkdiv_wr = 1'b0;
    clkdiv_wdata = 7'h00;
    cmd_wr = 1'b0;
    cmd_wdata = 8'h00;
    status_wr = 1'b0;
    status_wdata = 8'h00;
    protected_any = 4'h0;
    addr_protected = 1'b0;
    verify_pass = 4'h1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk_stat("reset_flags", 6'h30);
    bus(1'b0, `SZ_BYTE, 32'h0000_0103, 32'h0, 2'h2);
    chk_val("sense_on", 32'h1, sense_amp_en);
    repeat (4) @(posedge clk);
    #1;
    chk_val("sense_off", 32'h0, sense_amp_en);
    bus(1'b0, `SZ_HALF, 32'h0000_0202, 32'h0, 2'h2);
    bus(1'b0, `SZ_WORD, 32'h0003_FFFC, 32'h0, 2'h2);
    bus(1'b0, `SZ_HALF, 32'h0000_0201, 32'h0, 2'h1);
    bus(1'b0, `SZ_WORD, 32'h0000_0206, 32'h0, 2'h1);
    bus(1'b0, `SZ_WORD, 32'h0004_0000, 32'h0, 2'h0);
    bus(1'b1, `SZ_HALF, 32'h0000_0200, 32'h0, 2'h1);
    bus(1'b1, `SZ_BYTE, 32'h0000_0200, 32'h0, 2'h1);
    chk_stat("subword_acc", 6'h34);
    strobe(W_STAT, 8'h30);
    bus(1'b1, `SZ_WORD, 32'h0000_0100, 32'h1234_5678, 2'h2);
    chk_stat("no_divider", 6'h34);
    strobe(W_STAT, 8'h10);
    chk_stat("acc_clear", 6'h30);
    strobe(W_DIV, 8'h00);
    chk_stat("div_loaded", 6'h31);
    seq(32'h0000_0104, 32'hCAFE_F00D, 8'h20);
    wait_start(`CMD_PROGRAM, 32'h0000_0104, 32'hCAFE_F00D);
    chk_val("cc_busy", 32'h0, status.command_complete);
    wait_done();
    chk_stat("prog_done", 6'h31);
    seq(32'h0000_07FC, 32'h1111_2222, 8'h40);
    wait_start(`CMD_PAGE_ERASE, 32'h0000_0400, 32'h0);
    wait_done();
    seq(32'h0000_0010, 32'h0000_0005, 8'h05);
    wait_start(`CMD_VERIFY, 32'h0000_0010, 32'h0);
    wait_done();
    chk_stat("blank", 6'h33);
    strobe(W_STAT, 8'h04);
    chk_stat("blank_clear", 6'h31);
    @(posedge clk);
    protected_any <= 4'h1;
    bus(1'b1, `SZ_WORD, 32'h0000_0020, 32'h0, 2'h2);
    strobe(W_CMD, 8'h41);
    chk_stat("mass_prot", 6'h39);
    strobe(W_STAT, 8'h20);
    @(posedge clk);
    protected_any <= 4'h0;
    bus(1'b1, `SZ_WORD, 32'h0000_0020, 32'h0, 2'h2);
    strobe(W_CMD, 8'h33);
    chk_stat("bad_cmd", 6'h35);
    strobe(W_STAT, 8'h10);
    bus(1'b1, `SZ_WORD, 32'h0000_0020, 32'h0, 2'h2);
    strobe(W_STAT, 8'h00);
    chk_stat("abort", 6'h35);
    strobe(W_STAT, 8'h10);
    bus(1'b1, `SZ_WORD, 32'h0000_0020, 32'h0, 2'h2);
    strobe(W_CMD, 8'h20);
    strobe(W_STAT, 8'h00);
    chk_stat("cmd_abort", 6'h35);
    strobe(W_STAT, 8'h10);
    chk_stat("ready", 6'h31);
    @(posedge clk);
    key_access_enable <= 1'b1;
    bus(1'b1, `SZ_WORD, 32'h0000_0300, 32'hDEAD_BEEF, 2'h2);
    @(posedge clk);
    key_access_enable <= 1'b0;
    seq(32'h0000_0000, 32'h0, 8'h41);
    wait_start(`CMD_MASS_ERASE, 32'h0, 32'h0);
    seq(32'h0000_0008, 32'h0000_00FF, 8'h20);
    chk_val("queued_full", 32'h0, status.buffer_empty);
    strobe(W_CMD, 8'h33);
    chk_stat("cmd_ignored", 6'h01);
    @(posedge clk);
    bank_select <= 2'h1;
    seq(32'h0002_0010, 32'h0F0F_0F0F, 8'h20);
    wait_start(`CMD_PROGRAM, 32'h0002_0010, 32'h0F0F_0F0F);
    wait_done();
    @(posedge clk);
    bank_select <= 2'h0;
    @(posedge clk);
    #1;
    chk_val("bank0_busy", 32'h0, status.command_complete);
    wait_start(`CMD_PROGRAM, 32'h0000_0008, 32'h0000_00FF);
    wait_done();
    timed_prog(7'h00, 8, 12);
    timed_prog(7'h01, 18, 19);
    timed_prog(7'h03, 32, 44);
    timed_prog(7'h40, 64, 84);
    timed_prog(7'h41, 128, 164);
    // 100 MHz: prescale on, 12.5 MHz over 200 kHz truncates to 62
    timed_prog(7'h7E, 4034, 4537);
    close_out();
  end
endmodule // test_fm_sequencer
`default_nettype wire
